//--- verilog/logic_cell_params.svh
// register offsets, field positions and codes of the logic cell control
`ifndef LOGIC_CELL_PARAMS_SVH
`define LOGIC_CELL_PARAMS_SVH

// register indexes on the plain register port
`define LC_CTRL_IDX     3'h0
`define LC_INVERT_IDX   3'h1
`define LC_IRQ_STAT_IDX 3'h2
`define LC_IRQ_CLR_IDX  3'h3
`define LC_IRQ_EN_IDX   3'h4

// control register fields
`define LC_EN_BIT       7
`define LC_OE_BIT       6
`define LC_OUT_BIT      5
`define LC_INTP_BIT     4
`define LC_INTN_BIT     3
`define LC_MODE_HI      2
`define LC_MODE_LO      0

// invert register field, irq bit in status/clear/enable
`define LC_INV_BIT      7
`define LC_IRQ_BIT      0

// reset values
`define LC_CTRL_RST     8'h00
`define LC_INVERT_RST   8'h00

// logic function codes
`define LC_FN_ANDOR     3'h0
`define LC_FN_ORXOR     3'h1
`define LC_FN_AND4      3'h2
`define LC_FN_SRLATCH   3'h3
`define LC_FN_DFF_SR    3'h4
`define LC_FN_DFF_R     3'h5
`define LC_FN_JK_R      3'h6
`define LC_FN_TLATCH    3'h7

`endif

//--- verilog/logic_cell_pkg.sv
// types shared by the logic cell control block
`default_nettype none

package logic_cell_pkg;

    // one access on the register port
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // whole state of the cell control block
    typedef struct packed {
        logic       en;
        logic       oe;
        logic       intp;
        logic       intn;
        logic [2:0] mode;
        logic       inv;
        logic       g1Prev;
        logic       q;
        logic       cellOut;
        logic       flag;
        logic       irqEn;
        logic       irq;
        logic       pinOut;
        logic       pinOeB;
        logic [7:0] rdata;
    } cell_state_t;

endpackage

`default_nettype wire

//--- verilog/logic_cell_control.sv
// control, logic function, output stage and interrupt of one logic cell
`timescale 1ns/1ns
`default_nettype none
`include "logic_cell_params.svh"

module logic_cell_control (
    input  wire logic                      clk,     // 20 MHz clock
    input  wire logic                      rst_b,   // sync reset, low
    input  wire logic_cell_pkg::reg_req_t  regReq,  // register access
    input  wire logic [3:0]                gate,    // gate 1..4 outputs
    output var  logic [7:0]                regRdata, // read data, 1 cycle
    output var  logic                      cellOut, // cell output
    output var  logic                      pinOut,  // pin data
    output var  logic                      pinOeB,  // pin enable, low
    output var  logic                      irq      // level interrupt
);

    logic_cell_pkg::cell_state_t s_ff;
    logic_cell_pkg::cell_state_t nxt_s;
    logic                        logicRes;
    logic                        g1Rise;
    logic                        setS;
    logic                        clrR;
    logic                        wrCtrl;
    logic                        wrInv;
    logic                        wrClr;
    logic                        wrIrqEn;
    logic                        rdHit;

    // register write decode
    assign wrCtrl  = regReq.wr && (regReq.addr == `LC_CTRL_IDX);
    assign wrInv   = regReq.wr && (regReq.addr == `LC_INVERT_IDX);
    assign wrClr   = regReq.wr && (regReq.addr == `LC_IRQ_CLR_IDX);
    assign wrIrqEn = regReq.wr && (regReq.addr == `LC_IRQ_EN_IDX);
    assign rdHit   = regReq.rd;

    // gate 1 is the clock of the edge-clocked functions
    assign g1Rise = gate[0] && !s_ff.g1Prev;

    // logic function stage; sequential ones keep their bit in q
    always_comb begin
        logicRes = 1'b0;
        setS     = 1'b0;
        clrR     = 1'b0;
        case (s_ff.mode)
            `LC_FN_ANDOR: begin
                logicRes = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            end
            `LC_FN_ORXOR: begin
                logicRes = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            end
            `LC_FN_AND4: begin
                logicRes = &gate;
            end
            `LC_FN_SRLATCH: begin
                setS = gate[0] | gate[1];
                clrR = gate[2] | gate[3];
                // reset dominates when both are asserted
                if (clrR) begin
                    logicRes = 1'b0;
                end else if (setS) begin
                    logicRes = 1'b1;
                end else begin
                    logicRes = s_ff.q;
                end
            end
            `LC_FN_DFF_SR: begin
                if (gate[2]) begin
                    logicRes = 1'b0;
                end else if (gate[3]) begin
                    logicRes = 1'b1;
                end else if (g1Rise) begin
                    logicRes = gate[1];
                end else begin
                    logicRes = s_ff.q;
                end
            end
            `LC_FN_DFF_R: begin
                if (gate[2]) begin
                    logicRes = 1'b0;
                end else if (g1Rise) begin
                    logicRes = gate[1];
                end else begin
                    logicRes = s_ff.q;
                end
            end
            `LC_FN_JK_R: begin
                if (gate[2]) begin
                    logicRes = 1'b0;
                end else if (g1Rise) begin
                    case ({gate[1], gate[3]})
                        2'h1:    logicRes = 1'b0;
                        2'h2:    logicRes = 1'b1;
                        2'h3:    logicRes = !s_ff.q;
                        default: logicRes = s_ff.q;
                    endcase
                end else begin
                    logicRes = s_ff.q;
                end
            end
            `LC_FN_TLATCH: begin
                if (gate[2]) begin
                    logicRes = 1'b0;
                end else if (gate[3]) begin
                    logicRes = 1'b1;
                end else if (gate[0]) begin
                    logicRes = gate[1];
                end else begin
                    logicRes = s_ff.q;
                end
            end
            default: begin
                logicRes = 1'b0;
            end
        endcase
    end

    // next state: registers, output stage, edge flag, read data
    always_comb begin
        nxt_s = s_ff;
        nxt_s.g1Prev = gate[0];
        // a disabled cell holds its memory cleared and output low
        if (s_ff.en) begin
            nxt_s.q       = logicRes;
            nxt_s.cellOut = logicRes ^ s_ff.inv;
        end else begin
            nxt_s.q       = 1'b0;
            nxt_s.cellOut = 1'b0;
        end
        if (wrCtrl) begin
            // output status bit is read-only, write data dropped
            nxt_s.en   = regReq.wdata[`LC_EN_BIT];
            nxt_s.oe   = regReq.wdata[`LC_OE_BIT];
            nxt_s.intp = regReq.wdata[`LC_INTP_BIT];
            nxt_s.intn = regReq.wdata[`LC_INTN_BIT];
            nxt_s.mode = regReq.wdata[`LC_MODE_HI:`LC_MODE_LO];
        end
        if (wrInv) begin
            nxt_s.inv = regReq.wdata[`LC_INV_BIT];
        end
        if (wrIrqEn) begin
            nxt_s.irqEn = regReq.wdata[`LC_IRQ_BIT];
        end
        // clear first, so an edge in the same cycle still sets
        if (wrClr && regReq.wdata[`LC_IRQ_BIT]) begin
            nxt_s.flag = 1'b0;
        end
        // inversion toggles reach the detectors like any edge
        if (s_ff.intp && nxt_s.cellOut && !s_ff.cellOut) begin
            nxt_s.flag = 1'b1;
        end
        if (s_ff.intn && !nxt_s.cellOut && s_ff.cellOut) begin
            nxt_s.flag = 1'b1;
        end
        nxt_s.irq    = nxt_s.flag & nxt_s.irqEn;
        nxt_s.pinOut = nxt_s.oe & nxt_s.cellOut;
        nxt_s.pinOeB = !nxt_s.oe;
        nxt_s.rdata  = 8'h00;
        if (rdHit) begin
            case (regReq.addr)
                `LC_CTRL_IDX: begin
                    nxt_s.rdata = {s_ff.en, s_ff.oe, s_ff.cellOut,
                                   s_ff.intp, s_ff.intn, s_ff.mode};
                end
                `LC_INVERT_IDX: begin
                    nxt_s.rdata = {s_ff.inv, 7'h00};
                end
                `LC_IRQ_STAT_IDX: begin
                    nxt_s.rdata = {7'h00, s_ff.flag};
                end
                `LC_IRQ_EN_IDX: begin
                    nxt_s.rdata = {7'h00, s_ff.irqEn};
                end
                default: begin
                    nxt_s.rdata = 8'h00;
                end
            endcase
        end
    end

    // state register; reset clears the whole state and sets pinOeB high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_ff        <= '0;
            s_ff.pinOeB <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // all outputs straight from the state register
    assign regRdata = s_ff.rdata;
    assign cellOut  = s_ff.cellOut;
    assign pinOut   = s_ff.pinOut;
    assign pinOeB   = s_ff.pinOeB;
    assign irq      = s_ff.irq;

    // enabled cell follows the function through the invert stage
    property p_enabled_result;
        @(posedge clk) disable iff (!rst_b)
        s_ff.en |=> s_ff.cellOut == ($past(logicRes) ^ $past(s_ff.inv));
    endproperty
    a_enabled_result: assert property (p_enabled_result)
        else $error("cell output differs from function result");

    // disabled cell outputs zero one cycle later
    property p_disabled_zero;
        @(posedge clk) disable iff (!rst_b)
        !s_ff.en |=> !s_ff.cellOut && !s_ff.q;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("disabled cell output not zero");

    // pin enable tracks the control bit, pin data only when enabled
    property p_pin_gate;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.pinOeB == !s_ff.oe) && (s_ff.pinOut == (s_ff.oe & s_ff.cellOut));
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("pin drive disagrees with output enable");

    // control read returns the output value in its status bit
    property p_status_read;
        @(posedge clk) disable iff (!rst_b)
        (regReq.rd && regReq.addr == `LC_CTRL_IDX)
            |=> regRdata[`LC_OUT_BIT] == $past(s_ff.cellOut);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status bit does not show cell output");

    // enabled rising edge leaves the flag set
    property p_rise_flag;
        @(posedge clk) disable iff (!rst_b)
        ($rose(s_ff.cellOut) && $past(s_ff.intp)) |-> s_ff.flag;
    endproperty
    a_rise_flag: assert property (p_rise_flag)
        else $error("rising edge did not set flag");

    // enabled falling edge leaves the flag set
    property p_fall_flag;
        @(posedge clk) disable iff (!rst_b)
        ($fell(s_ff.cellOut) && $past(s_ff.intn)) |-> s_ff.flag;
    endproperty
    a_fall_flag: assert property (p_fall_flag)
        else $error("falling edge did not set flag");

    // flag rises only by an enabled edge of the output
    property p_flag_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(s_ff.flag) |-> ($rose(s_ff.cellOut) && $past(s_ff.intp))
                          || ($fell(s_ff.cellOut) && $past(s_ff.intn));
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag set without enabled edge");

    // flag stays until software clears it
    property p_flag_sticky;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.flag && !(wrClr && regReq.wdata[`LC_IRQ_BIT])) |=> s_ff.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag lost without a clear");

    // D flip-flop with reset takes data on gate 1 rising edge
    property p_dff_r;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.en && s_ff.mode == `LC_FN_DFF_R && g1Rise && !gate[2])
            |=> s_ff.q == $past(gate[1]);
    endproperty
    a_dff_r: assert property (p_dff_r)
        else $error("flip-flop with reset missed its data");

    // set input of the set/reset flip-flop forces one
    property p_dff_sr_set;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.en && s_ff.mode == `LC_FN_DFF_SR && gate[3] && !gate[2])
            |=> s_ff.q;
    endproperty
    a_dff_sr_set: assert property (p_dff_sr_set)
        else $error("set input did not force one");

    // after reset the control fields are zero
    property p_reset_clear;
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !s_ff.en && !s_ff.oe && !s_ff.intp && !s_ff.intn
                         && s_ff.mode == `LC_FN_ANDOR && !s_ff.cellOut;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control not cleared by reset");

    // interrupt line follows enabled flag
    property p_irq_level;
        @(posedge clk) disable iff (!rst_b)
        irq == (s_ff.flag && s_ff.irqEn);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line disagrees with flag");

    // enabled four-input and follows all gates through the invert stage
    property p_and4;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.en && s_ff.mode == `LC_FN_AND4)
            |=> s_ff.cellOut == ($past(&gate) ^ $past(s_ff.inv));
    endproperty
    a_and4: assert property (p_and4)
        else $error("four-input and result wrong");

    // control write lands in enable and function fields at once
    property p_ctrl_write;
        @(posedge clk) disable iff (!rst_b)
        wrCtrl |=> s_ff.en == $past(regReq.wdata[`LC_EN_BIT])
            && s_ff.mode == $past(regReq.wdata[`LC_MODE_HI:`LC_MODE_LO]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write did not land");

    // both inputs high on a gate 1 rise toggle the flip-flop
    property p_jk_toggle;
        @(posedge clk) disable iff (!rst_b)
        (s_ff.en && s_ff.mode == `LC_FN_JK_R && g1Rise && !gate[2]
            && gate[1] && gate[3]) |=> s_ff.q != $past(s_ff.q);
    endproperty
    a_jk_toggle: assert property (p_jk_toggle)
        else $error("flip-flop did not toggle");

    // a clear empties the flag unless an output edge came with it
    property p_flag_clear;
        @(posedge clk) disable iff (!rst_b)
        (wrClr && regReq.wdata[`LC_IRQ_BIT])
            |=> !s_ff.flag || $changed(s_ff.cellOut);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag survived a clear with no edge");

endmodule

`default_nettype wire

//--- verif/logic_cell_control_test.sv
// self-checking bench of the logic cell control block
`timescale 1ns/1ns
`default_nettype none
`include "logic_cell_params.svh"

// compare, count, report at once
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end

module logic_cell_control_test;
    logic                     clk;
    logic                     rst_b;
    logic_cell_pkg::reg_req_t regReq;
    logic [3:0]               gate;
    logic [7:0]               regRdata;
    logic                     cellOut;
    logic                     pinOut;
    logic                     pinOeB;
    logic                     irq;
    logic [7:0]               rdVal;
    int                       err_total;
    int                       checks;

    logic_cell_control i_dut (
        .clk      (clk),
        .rst_b    (rst_b),
        .regReq   (regReq),
        .gate     (gate),
        .regRdata (regRdata),
        .cellOut  (cellOut),
        .pinOut   (pinOut),
        .pinOeB   (pinOeB),
        .irq      (irq)
    );

    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // strobe lowered on the taking edge, so back-to-back calls stay legal
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        @(posedge clk);
        regReq <= {idx, d, 1'b1, 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] idx, output logic [7:0] d);
        @(posedge clk);
        regReq <= {idx, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        regReq <= '0;
        #1;
        d = regRdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic put(input logic [3:0] g);
        @(posedge clk);
        gate <= g;
        settle();
    endtask

    task automatic clr();
        wr(`LC_IRQ_CLR_IDX, 8'h01);
        settle();
    endtask

    function automatic logic comb(input logic [2:0] m, input logic [3:0] g);
        case (m)
            3'h0:    return (g[0] & g[1]) | (g[2] & g[3]);
            3'h1:    return (g[0] | g[1]) ^ (g[2] | g[3]);
            default: return &g;
        endcase
    endfunction

    task automatic t_reset();
        rd_reg(`LC_CTRL_IDX, rdVal);
        `CHK(rdVal, `LC_CTRL_RST)
        rd_reg(`LC_INVERT_IDX, rdVal);
        `CHK(rdVal, 8'h00)
        rd_reg(3'h7, rdVal);
        `CHK(rdVal, 8'h00)
        `CHK(cellOut, 1'b0)
        `CHK(pinOeB, 1'b1)
        `CHK(irq, 1'b0)
    endtask

    // every gate pattern through the three combinational codes
    task automatic t_comb();
        logic [3:0] g;
        for (int m = 0; m < 3; m++) begin
            wr(`LC_CTRL_IDX, {5'b10000, m[2:0]});
            for (int i = 0; i < 16; i++) begin
                g = i[3:0];
                put(g);
                `CHK(cellOut, comb(m[2:0], g))
                `CHK(pinOut, 1'b0)
                `CHK(pinOeB, 1'b1)
                rd_reg(`LC_CTRL_IDX, rdVal);
                `CHK(rdVal, {2'b10, comb(m[2:0], g), 2'b00, m[2:0]})
            end
        end
    endtask

    task automatic t_pin();
        wr(`LC_CTRL_IDX, 8'hc2);
        put(4'h0);
        `CHK(pinOeB, 1'b0)
        wr(`LC_CTRL_IDX, 8'he2);
        rd_reg(`LC_CTRL_IDX, rdVal);
        `CHK(rdVal, 8'hc2)
        wr(`LC_INVERT_IDX, 8'h80);
        settle();
        `CHK(cellOut, 1'b1)
        `CHK(pinOut, 1'b1)
        wr(`LC_CTRL_IDX, 8'h42);
        settle();
        `CHK(cellOut, 1'b0)
        `CHK(pinOut, 1'b0)
        wr(`LC_CTRL_IDX, 8'h02);
        settle();
        `CHK(pinOeB, 1'b1)
        wr(`LC_INVERT_IDX, 8'h00);
    endtask

    task automatic t_irq();
        wr(`LC_IRQ_EN_IDX, 8'h01);
        wr(`LC_CTRL_IDX, 8'h92);
        put(4'h0);
        clr();
        put(4'hf);
        `CHK(irq, 1'b1)
        clr();
        `CHK(irq, 1'b0)
        put(4'h0);
        `CHK(irq, 1'b0)
        wr(`LC_CTRL_IDX, 8'h8a);
        put(4'hf);
        `CHK(irq, 1'b0)
        put(4'h0);
        `CHK(irq, 1'b1)
        clr();
        wr(`LC_INVERT_IDX, 8'h80);
        wr(`LC_INVERT_IDX, 8'h00);
        settle();
        `CHK(irq, 1'b1)
        clr();
        wr(`LC_IRQ_EN_IDX, 8'h00);
        put(4'hf);
        put(4'h0);
        `CHK(irq, 1'b0)
        rd_reg(`LC_IRQ_STAT_IDX, rdVal);
        `CHK(rdVal, 8'h01)
        wr(`LC_IRQ_EN_IDX, 8'h01);
        settle();
        `CHK(irq, 1'b1)
        clr();
        // falling edge lands on the same edge as the clear write
        put(4'hf);
        @(posedge clk);
        gate <= 4'h0;
        regReq <= {`LC_IRQ_CLR_IDX, 8'h01, 1'b1, 1'b0};
        @(posedge clk);
        regReq <= '0;
        settle();
        `CHK(irq, 1'b1)
        clr();
    endtask

    // steps of {code, gates, expected output}; gate1 is the cell clock
    task automatic t_seq();
        logic [7:0] s [$];
        s = '{{3'h5, 4'h4, 1'b0}, {3'h5, 4'h2, 1'b0}, {3'h5, 4'h3, 1'b1},
              {3'h5, 4'h1, 1'b1}, {3'h5, 4'h5, 1'b0}, {3'h4, 4'h8, 1'b1},
              {3'h4, 4'h0, 1'b1}, {3'h4, 4'h4, 1'b0}, {3'h4, 4'hc, 1'b0},
              {3'h4, 4'h2, 1'b0}, {3'h4, 4'h3, 1'b1}, {3'h3, 4'h1, 1'b1},
              {3'h3, 4'h0, 1'b1}, {3'h3, 4'h4, 1'b0}, {3'h6, 4'h4, 1'b0},
              {3'h6, 4'h2, 1'b0}, {3'h6, 4'h3, 1'b1}, {3'h6, 4'ha, 1'b1},
              {3'h6, 4'hb, 1'b0}, {3'h6, 4'h7, 1'b0}, {3'h7, 4'h8, 1'b1},
              {3'h7, 4'h4, 1'b0}, {3'h7, 4'h3, 1'b1}, {3'h7, 4'h1, 1'b0}};
        for (int i = 0; i < s.size(); i++) begin
            if (i == 0 || s[i][7:5] != s[i-1][7:5]) begin
                wr(`LC_CTRL_IDX, {5'b10000, s[i][7:5]});
            end
            put(s[i][4:1]);
            `CHK(cellOut, s[i][0])
        end
    endtask

    task automatic t_reset_mid();
        wr(`LC_CTRL_IDX, 8'hda);
        put(4'hf);
        `CHK(pinOeB, 1'b0)
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK(pinOeB, 1'b1)
        rd_reg(`LC_CTRL_IDX, rdVal);
        `CHK(rdVal, 8'h00)
        settle();
        `CHK(cellOut, 1'b0)
    endtask

    // main sequence
    initial begin
        rst_b     = 1'b0;
        regReq    = '0;
        gate      = 4'h0;
        err_total = 0;
        checks    = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_comb();
        t_pin();
        t_irq();
        t_seq();
        t_reset_mid();
        finish_test();
    end

    // run needs about 450 cycles; hang cut well beyond that
    initial begin
        #(50 * 20000);
        err_total++;
        finish_test();
    end
endmodule

`default_nettype wire
